// >>> pkg/hwd_pkg.sv
/*
  package for the high-voltage wake input detector: register offsets, field
  positions, reset values, timing constants, mode enum and carrier structs.
  assumes a single 200 MHz clock and a plain strobe register port.
*/
package hwd_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 200;
  localparam int unsigned FILTER_TIME_US = 16;
  localparam int unsigned FILTER_CYC = FILTER_TIME_US * CLK_MHZ;
  localparam int unsigned INT_PULSE_US = 100;
  localparam int unsigned INT_PULSE_CYC = INT_PULSE_US * CLK_MHZ;
  localparam int unsigned CNT_W = 15;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [3:0] ADDR_WAKE_CTRL = 4'h0;
  localparam logic [3:0] ADDR_BIAS_CTRL = 4'h1;
  localparam logic [3:0] ADDR_MEAS_CTRL = 4'h2;
  localparam logic [3:0] ADDR_STAT_A = 4'h3;
  localparam logic [3:0] ADDR_STAT_B = 4'h4;
  localparam logic [3:0] ADDR_LEVEL = 4'h5;

  // wake_enable_ctrl fields
  localparam int unsigned WC_PIN_EN = 0;
  localparam int unsigned WC_GP_EN = 1;
  localparam int unsigned WC_CYCLIC = 2;
  // bias_source_ctrl fields
  localparam int unsigned BS_LO = 0;
  localparam int unsigned BS_HI = 1;
  // measure ctrl fields
  localparam int unsigned MC_MEAS = 0;
  localparam int unsigned MC_FO_TEST = 1;
  // status fields
  localparam int unsigned ST_PIN_WAKE = 0;
  localparam int unsigned ST_GP_WAKE = 0;
  localparam int unsigned LV_PIN = 0;
  localparam int unsigned LV_GP = 1;

  localparam logic [7:0] RST_WAKE_CTRL = 8'h01;
  localparam logic [7:0] RST_BIAS_CTRL = 8'h00;
  localparam logic [7:0] RST_MEAS_CTRL = 8'h00;

  localparam logic [1:0] BIAS_NONE = 2'h0;
  localparam logic [1:0] BIAS_DOWN = 2'h1;
  localparam logic [1:0] BIAS_UP = 2'h2;
  localparam logic [1:0] BIAS_AUTO = 2'h3;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    HWD_NORMAL = 2'h0,
    HWD_STOP = 2'h1,
    HWD_SLEEP = 2'h3,
    HWD_FAILSAFE = 2'h2
  } hwd_mode_e;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } hwd_req_s;

  typedef struct packed {
    logic pull_up;
    logic pull_down;
  } hwd_bias_s;

endpackage

// >>> verilog/hwd_wake_detect.sv
/*
  wake input detector: synchronises the comparator outputs of the wake pin and
  of the general pin, filters them, detects edges, records events and levels,
  steers the bias sources and raises an interrupt pulse or a wake request.
  assumes comparator outputs are asynchronous, timer window and mode come
  from same-clock logic, and the register port is a plain strobe port.
*/
`timescale 1ns/10ps
`default_nettype none

module hwd_wake_detect (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire hwd_pkg::hwd_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic hv_wake_pin,
  input wire logic fail_or_general_pin,
  input wire logic gp_is_wake_input,
  input wire logic hs_window,
  input wire logic init_mode,
  input wire hwd_pkg::hwd_mode_e sbc_mode,
  input wire logic sleep_request,
  input wire logic other_wake_src,
  output hwd_pkg::hwd_bias_s bias,
  output logic int_n,
  output logic wake_req,
  output logic fail_out_allowed,
  output logic gp_func_allowed,
  output logic spi_fail,
  output logic restart_req
);
  import hwd_pkg::*;

  // ****************************************
  // registers and synchronisers
  // ****************************************
  logic [7:0] wake_enable_ctrl_q;
  logic [7:0] bias_source_ctrl_q;
  logic [7:0] meas_ctrl_q;
  logic wake_event_status_a_q;
  logic wake_event_status_b_q;
  logic [1:0] pin_level_status_q;
  logic [1:0] sync1_q;
  logic [1:0] sync2_q;
  logic [1:0] filt_lvl_q;
  logic [CNT_W-1:0] filt_cnt_q [2];
  logic sample_q;
  logic sample_vld_q;
  logic meas;
  logic [1:0] edge_ev;
  logic cyc_ev;
  logic pin_ev;
  logic gp_ev;
  logic any_ev;
  logic [CNT_W-1:0] int_cnt_q;
  logic [1:0] bias_sel;
  logic cyc_mode;
  logic lvl_upd;
  logic wr_wake_ctrl;
  logic wr_bias_ctrl;
  logic wr_meas_ctrl;
  logic clr_stat_a;
  logic clr_stat_b;
  logic clr_spi_fail;
  logic mode_awake;
  logic mode_asleep;
  logic bad_sleep;

  assign meas = meas_ctrl_q[MC_MEAS];
  assign bias_sel = {bias_source_ctrl_q[BS_HI], bias_source_ctrl_q[BS_LO]};
  assign cyc_mode = wake_enable_ctrl_q[WC_CYCLIC];
  assign lvl_upd = init_mode || (sbc_mode == HWD_NORMAL) || (sbc_mode == HWD_STOP);

  // strobe decodes, shared by the register and flag processes
  assign wr_wake_ctrl = reg_req.wr && (reg_req.addr == ADDR_WAKE_CTRL);
  assign wr_bias_ctrl = reg_req.wr && (reg_req.addr == ADDR_BIAS_CTRL);
  assign wr_meas_ctrl = reg_req.wr && (reg_req.addr == ADDR_MEAS_CTRL);
  assign clr_stat_a = reg_req.wr && (reg_req.addr == ADDR_STAT_A) && reg_req.wdata[ST_PIN_WAKE];
  assign clr_stat_b = reg_req.wr && (reg_req.addr == ADDR_STAT_B) && reg_req.wdata[ST_GP_WAKE];
  assign clr_spi_fail = wr_meas_ctrl && reg_req.wdata[MC_FO_TEST];
  assign mode_awake = (sbc_mode == HWD_NORMAL) || (sbc_mode == HWD_STOP);
  assign mode_asleep = (sbc_mode == HWD_SLEEP) || (sbc_mode == HWD_FAILSAFE);
  // a pin that measurement has gated cannot be the only way out of sleep
  assign bad_sleep = sleep_request && meas && !other_wake_src;

  // the first stage feeds only the second; metastability stays contained
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= {fail_or_general_pin, hv_wake_pin};
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // static filters, one per input
  // ****************************************
  // counter restarts while input equals filtered level, so any crossing back
  // before expiry discards the pulse
  for (genvar i = 0; i < 2; i++) begin : g_filt
    always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
        filt_cnt_q[i] <= '0;
        filt_lvl_q[i] <= 1'b0;
      end else if (sync2_q[i] == filt_lvl_q[i]) begin
        filt_cnt_q[i] <= '0;
      end else if (filt_cnt_q[i] == CNT_W'(FILTER_CYC - 1)) begin
        filt_cnt_q[i] <= '0;
        filt_lvl_q[i] <= sync2_q[i];
      end else begin
        filt_cnt_q[i] <= filt_cnt_q[i] + CNT_W'(1);
      end
    end
    assign edge_ev[i] = (sync2_q[i] != filt_lvl_q[i])
                        && (filt_cnt_q[i] == CNT_W'(FILTER_CYC - 1));
  end

  // ****************************************
  // cyclic sensing
  // ****************************************
  // window comes from the timer driven high-side switch set up by software
  // last sample is kept outside the window so the level register can show it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sample_q <= 1'b0;
    end else if (cyc_mode && hs_window) begin
      sample_q <= sync2_q[0];
    end
  end

  // first window cycle after enabling has nothing to compare against
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      sample_vld_q <= 1'b0;
    end else if (!cyc_mode) begin
      sample_vld_q <= 1'b0;
    end else if (hs_window) begin
      sample_vld_q <= 1'b1;
    end
  end
  assign cyc_ev = wake_enable_ctrl_q[WC_CYCLIC] && hs_window && sample_vld_q
                  && (sample_q != sync2_q[0]);

  assign pin_ev = !meas && wake_enable_ctrl_q[WC_PIN_EN]
                  && (wake_enable_ctrl_q[WC_CYCLIC] ? cyc_ev : edge_ev[0]);
  assign gp_ev = !meas && gp_is_wake_input && wake_enable_ctrl_q[WC_GP_EN]
                 && edge_ev[1];
  assign any_ev = pin_ev || gp_ev;

  // ****************************************
  // register writes
  // ****************************************
  // configuration stays writable while measurement ignores it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_enable_ctrl_q <= RST_WAKE_CTRL;
    end else if (wr_wake_ctrl) begin
      wake_enable_ctrl_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      bias_source_ctrl_q <= RST_BIAS_CTRL;
    end else if (wr_bias_ctrl) begin
      bias_source_ctrl_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      meas_ctrl_q <= RST_MEAS_CTRL;
    end else if (wr_meas_ctrl) begin
      meas_ctrl_q <= reg_req.wdata;
    end
  end

  // status flags: write 1 clears, a same-cycle event wins so none is lost
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_event_status_a_q <= 1'b0;
    end else if (pin_ev) begin
      wake_event_status_a_q <= 1'b1;
    end else if (clr_stat_a) begin
      wake_event_status_a_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_event_status_b_q <= 1'b0;
    end else if (gp_ev) begin
      wake_event_status_b_q <= 1'b1;
    end else if (clr_stat_b) begin
      wake_event_status_b_q <= 1'b0;
    end
  end

  // level status: live or sampled, cleared under measurement
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pin_level_status_q <= 2'h0;
    end else if (meas) begin
      pin_level_status_q <= 2'h0;
    end else if (lvl_upd) begin
      pin_level_status_q[LV_PIN] <= cyc_mode ? sample_q : sync2_q[0];
      pin_level_status_q[LV_GP] <= sync2_q[1];
    end
  end

  // ****************************************
  // register reads, data one cycle later
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        ADDR_WAKE_CTRL: reg_rdata <= wake_enable_ctrl_q;
        ADDR_BIAS_CTRL: reg_rdata <= bias_source_ctrl_q;
        ADDR_MEAS_CTRL: reg_rdata <= meas_ctrl_q;
        ADDR_STAT_A: reg_rdata <= {7'h00, wake_event_status_a_q};
        ADDR_STAT_B: reg_rdata <= {7'h00, wake_event_status_b_q};
        ADDR_LEVEL: reg_rdata <= {6'h00, pin_level_status_q};
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ****************************************
  // bias current sources
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (sys_rst || meas) begin
      bias <= '0;
    end else begin
      case (bias_sel)
        BIAS_DOWN: bias <= '{pull_up: 1'b0, pull_down: 1'b1};
        BIAS_UP: bias <= '{pull_up: 1'b1, pull_down: 1'b0};
        BIAS_AUTO: bias <= '{pull_up: filt_lvl_q[0], pull_down: !filt_lvl_q[0]};
        default: bias <= '0;
      endcase
    end
  end

  // ****************************************
  // interrupt pulse or wake request
  // ****************************************
  // in normal or stop mode, events arriving during a running pulse are kept only in status
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_cnt_q <= '0;
    end else if (int_cnt_q != '0) begin
      int_cnt_q <= int_cnt_q - CNT_W'(1);
    end else if (any_ev && mode_awake) begin
      int_cnt_q <= CNT_W'(INT_PULSE_CYC);
    end
  end

  // released in the cycle the count runs out, so the low time is exact
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_n <= 1'b1;
    end else if (int_cnt_q != '0) begin
      int_n <= (int_cnt_q == CNT_W'(1));
    end else if (any_ev && mode_awake) begin
      int_n <= 1'b0;
    end
  end

  // a single pulse; the mode controller is expected to latch it
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= any_ev && mode_asleep;
    end
  end

  // ****************************************
  // measurement side effects
  // ****************************************
  // fail output and general pin both give way to the measurement path
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      fail_out_allowed <= 1'b1;
    end else begin
      fail_out_allowed <= !meas;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gp_func_allowed <= 1'b1;
    end else begin
      gp_func_allowed <= !meas;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      restart_req <= 1'b0;
    end else begin
      restart_req <= bad_sleep;
    end
  end

  // sticky until software clears it; a refused sleep in the same cycle wins
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      spi_fail <= 1'b0;
    end else if (bad_sleep) begin
      spi_fail <= 1'b1;
    end else if (clr_spi_fail) begin
      spi_fail <= 1'b0;
    end
  end

endmodule // hwd_wake_detect

`default_nettype wire

// >>> verification/hwd_wake_detect_sva.sv
/* checker on the ports of hwd_wake_detect.
   assumes the bind below and the single clock domain. */
`timescale 1ns/10ps
`default_nettype none
module hwd_wake_detect_sva (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire hwd_pkg::hwd_mode_e sbc_mode,
  input wire logic sleep_request,
  input wire logic other_wake_src,
  input wire hwd_pkg::hwd_bias_s bias,
  input wire logic int_n,
  input wire logic wake_req,
  input wire logic fail_out_allowed,
  input wire logic gp_func_allowed,
  input wire logic spi_fail,
  input wire logic restart_req
);
  import hwd_pkg::*;
  // *****
  // assertions
  // *****
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  logic [CNT_W-1:0] low_q;
  // length of the running interrupt pulse; a repetition could not reach it
  always_ff @(posedge sys_clk) begin
    if (sys_rst || int_n)
      low_q <= '0;
    else
      low_q <= low_q + CNT_W'(1);
  end
  sequence s_meas;
    !fail_out_allowed ##1 !fail_out_allowed;
  endsequence
  sequence s_bad_sleep;
    sleep_request && !other_wake_src && !fail_out_allowed;
  endsequence
  property p_int_len; $rose(int_n) |-> low_q == CNT_W'(INT_PULSE_CYC); endproperty
  a_int_len: assert property (p_int_len) else $error("int pulse width");
  property p_int_mode; $fell(int_n) |-> $past(sbc_mode) inside {HWD_NORMAL, HWD_STOP}; endproperty
  a_int_mode: assert property (p_int_mode) else $error("int in wrong mode");
  property p_wake_mode;
    wake_req |-> $past(sbc_mode) inside {HWD_SLEEP, HWD_FAILSAFE} ##1 !wake_req;
  endproperty
  a_wake_mode: assert property (p_wake_mode) else $error("wake in wrong mode");
  property p_meas_bias; s_meas |-> bias == '0; endproperty
  a_meas_bias: assert property (p_meas_bias) else $error("bias under measure");
  property p_meas_quiet; s_meas |-> !wake_req && !$fell(int_n); endproperty
  a_meas_quiet: assert property (p_meas_quiet) else $error("wake under measure");
  property p_meas_pins; fail_out_allowed == gp_func_allowed; endproperty
  a_meas_pins: assert property (p_meas_pins) else $error("pin gating split");
  property p_restart; s_bad_sleep |=> restart_req && spi_fail ##1 !restart_req; endproperty
  a_restart: assert property (p_restart) else $error("no restart");
  property p_bias_excl; !(bias.pull_up && bias.pull_down); endproperty
  a_bias_excl: assert property (p_bias_excl) else $error("both bias on");
endmodule // hwd_wake_detect_sva
bind hwd_wake_detect hwd_wake_detect_sva i_sva (.sys_clk, .sys_rst, .sbc_mode, .sleep_request,
  .other_wake_src, .bias, .int_n, .wake_req, .fail_out_allowed, .gp_func_allowed, .spi_fail,
  .restart_req);
`default_nettype wire

// >>> verification/hwd_pin_model.sv
/* far-side model: switches on the wake pin and the general pin.
   assumes the bench calls its tasks. */
`timescale 1ns/10ps
`default_nettype none
module hwd_pin_model (
  input wire logic sys_clk,
  output logic hv_wake_pin,
  output logic fail_or_general_pin
);
  // *****
  // lines always driven, so the comparators never see a float
  // *****
  initial begin
    hv_wake_pin = 1'b0;
    fail_or_general_pin = 1'b0;
  end
  task automatic set_pin(input logic gp, input logic v);
    @(posedge sys_clk);
    if (gp)
      fail_or_general_pin <= v;
    else
      hv_wake_pin <= v;
  endtask
  // contact bounce, held n+1 cycles
  task automatic glitch(input int n);
    set_pin(1'b0, ~hv_wake_pin);
    repeat (n) @(posedge sys_clk);
    set_pin(1'b0, ~hv_wake_pin);
  endtask
endmodule // hwd_pin_model
`default_nettype wire

// >>> verification/hwd_wake_detect_tb.sv
/* bench for hwd_wake_detect: bus tasks and one task per scenario.
   assumes the pin model and the bound checker. */
`timescale 1ns/10ps
`default_nettype none
module hwd_wake_detect_tb;
  import hwd_pkg::*;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  hwd_req_s reg_req = '0;
  hwd_mode_e mode = HWD_NORMAL;
  logic gp_wk = 1'b0, hs_win = 1'b0, slp = 1'b0, oth = 1'b0, ini = 1'b0;
  logic pin, gp_pin, int_n, wake_req, fo_ok, gp_ok, spi_fail, restart_req;
  logic [7:0] reg_rdata;
  hwd_bias_s bias;
  int n_fail = 0, samples_checked = 0, k;
  always #2.5 sys_clk = ~sys_clk;
  hwd_pin_model i_pin (.sys_clk, .hv_wake_pin(pin), .fail_or_general_pin(gp_pin));
  hwd_wake_detect i_dut (.sys_clk, .sys_rst, .reg_req, .reg_rdata, .hv_wake_pin(pin),
    .fail_or_general_pin(gp_pin), .gp_is_wake_input(gp_wk), .hs_window(hs_win),
    .init_mode(ini), .sbc_mode(mode), .sleep_request(slp), .other_wake_src(oth), .bias,
    .int_n, .wake_req, .fail_out_allowed(fo_ok), .gp_func_allowed(gp_ok), .spi_fail,
    .restart_req);
  // *****
  // shared tasks
  // *****
  task automatic stop_test;
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge sys_clk);
    reg_req.wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string nm);
    @(posedge sys_clk);
    reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge sys_clk);
    reg_req.rd <= 1'b0;
    #1;
    chk(nm, e, reg_rdata);
  endtask
  task automatic win;
    hs_win <= 1'b1;
    cyc(2);
    hs_win <= 1'b0;
  endtask
  // *****
  // scenarios
  // *****
  task automatic t_filter;
    rd(ADDR_WAKE_CTRL, RST_WAKE_CTRL, "wake_ctrl");
    rd(4'hF, 8'h00, "unmapped");
    i_pin.glitch(3100);
    cyc(3300);
    rd(ADDR_STAT_A, 8'h00, "glitch");
    i_pin.set_pin(1'b0, 1'b1);
    cyc(3190);
    rd(ADDR_STAT_A, 8'h00, "early");
    cyc(20);
    rd(ADDR_STAT_A, 8'h01, "rise");
    chk("int_n", 8'h00, {7'h0, int_n});
    rd(ADDR_LEVEL, 8'h01, "level");
    wr(ADDR_STAT_A, 8'h01);
    i_pin.set_pin(1'b0, 1'b0);
    cyc(3300);
    rd(ADDR_STAT_A, 8'h01, "fall");
  endtask
  task automatic t_bias;
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_BIAS_CTRL, 8'(i));
      cyc(2);
      chk("bias", 8'(i), {6'h0, bias});
    end
    wr(ADDR_BIAS_CTRL, 8'h03);
    cyc(2);
    chk("auto lo", 8'h01, {6'h0, bias});
    i_pin.set_pin(1'b0, 1'b1);
    cyc(3300);
    chk("auto hi", 8'h02, {6'h0, bias});
  endtask
  task automatic t_gp;
    gp_wk <= 1'b1;
    wr(ADDR_WAKE_CTRL, 8'h02);
    wr(ADDR_STAT_A, 8'h01);
    i_pin.set_pin(1'b0, 1'b0);
    i_pin.set_pin(1'b1, 1'b1);
    cyc(3300);
    rd(ADDR_STAT_A, 8'h00, "pin off");
    rd(ADDR_STAT_B, 8'h01, "stat_b");
    rd(ADDR_LEVEL, 8'h02, "level gp");
    i_pin.set_pin(1'b0, 1'b1);
    cyc(3300);
  endtask
  task automatic t_sleep;
    for (k = 0; int_n !== 1'b1 && k < 20000; k++)
      @(posedge sys_clk);
    wr(ADDR_WAKE_CTRL, 8'h01);
    mode <= HWD_SLEEP;
    i_pin.set_pin(1'b0, 1'b0);
    for (k = 0; wake_req !== 1'b1 && k < 3400; k++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("wake_req", 8'h01, {7'h0, wake_req});
    chk("int_n idle", 8'h01, {7'h0, int_n});
    rd(ADDR_LEVEL, 8'h03, "lvl sleep");
    @(posedge sys_clk);
    ini <= 1'b1;
    cyc(3);
    rd(ADDR_LEVEL, 8'h02, "lvl init");
    @(posedge sys_clk);
    ini <= 1'b0;
  endtask
  task automatic t_cyclic;
    mode <= HWD_NORMAL;
    i_pin.set_pin(1'b0, 1'b1);
    wr(ADDR_WAKE_CTRL, 8'h05);
    win();
    wr(ADDR_STAT_A, 8'h01);
    i_pin.set_pin(1'b0, 1'b0);
    cyc(10);
    rd(ADDR_LEVEL, 8'h03, "held");
    rd(ADDR_STAT_A, 8'h00, "between");
    win();
    rd(ADDR_STAT_A, 8'h01, "sampled");
    rd(ADDR_LEVEL, 8'h02, "sample");
  endtask
  task automatic t_meas;
    wr(ADDR_WAKE_CTRL, 8'h01);
    cyc(3300);
    wr(ADDR_STAT_A, 8'h01);
    wr(ADDR_MEAS_CTRL, 8'h01);
    wr(ADDR_BIAS_CTRL, 8'h02);
    rd(ADDR_BIAS_CTRL, 8'h02, "bias wr");
    chk("bias meas", 8'h00, {6'h0, bias});
    chk("fo_ok", 8'h00, {7'h0, fo_ok});
    chk("gp_ok", 8'h00, {7'h0, gp_ok});
    rd(ADDR_LEVEL, 8'h00, "lvl meas");
    i_pin.set_pin(1'b0, 1'b1);
    cyc(3300);
    rd(ADDR_STAT_A, 8'h00, "stat meas");
    @(posedge sys_clk);
    oth <= 1'b1;
    slp <= 1'b1;
    @(posedge sys_clk);
    slp <= 1'b0;
    #1;
    chk("restart other", 8'h00, {7'h0, restart_req});
    chk("spi other", 8'h00, {7'h0, spi_fail});
    @(posedge sys_clk);
    oth <= 1'b0;
    slp <= 1'b1;
    @(posedge sys_clk);
    slp <= 1'b0;
    #1;
    chk("restart", 8'h01, {7'h0, restart_req});
    chk("spi_fail", 8'h01, {7'h0, spi_fail});
  endtask
  initial begin
    cyc(5);
    sys_rst <= 1'b0;
    t_filter();
    t_bias();
    t_gp();
    t_sleep();
    t_cyclic();
    t_meas();
    stop_test();
  end
  // about 40000 cycles of tests; cut at 100000
  initial begin
    #500000;
    n_fail++;
    stop_test();
  end
endmodule // hwd_wake_detect_tb
`default_nettype wire
